// ==== src/blt_pkg.sv ====
package blt_pkg;
	// Register byte offsets
	localparam logic [11:0] OFF_CFG = 12'h07C;
	localparam logic [11:0] OFF_ROP = 12'h08C;
	localparam logic [11:0] OFF_SBASE = 12'h098;
	localparam logic [11:0] OFF_SPITCH = 12'h0AC;
	localparam logic [11:0] OFF_SXY = 12'h0BC;
	localparam logic [11:0] OFF_WIDTH = 12'h0C8;
	localparam logic [11:0] OFF_SCR = 12'h0D4;
	localparam logic [11:0] OFF_SKEY = 12'h0EC;
	localparam logic [11:0] OFF_DKEY = 12'h0FC;
	localparam logic [11:0] OFF_DXY = 12'h100;
	localparam logic [11:0] OFF_STAT = 12'h908;
	// Command aperture: paddr[11:10] selects it, paddr[9:2] is the count
	localparam logic [1:0] CMD_SEL = 2'h1;
	// Field positions
	localparam int ROP_SRC_LO = 30;
	localparam int ROP_DST_KEY = 15;
	localparam int ROP_DST_MATCH = 14;
	localparam int ROP_SRC_KEY = 13;
	localparam int ROP_SRC_MATCH = 12;
	localparam int ROP_PACKED = 11;
	localparam int ROP_EXPAND = 10;
	localparam int ROP_PAT_KEY = 9;
	localparam int ROP_BMP_KEY = 8;
	localparam int STAT_BUSY = 31;
	localparam int STAT_PEND = 30;
	localparam int CFG_YDIR = 7;
	// Write masks for reserved bits
	localparam logic [31:0] SBASE_MASK = 32'h003F_FFE0;
	localparam logic [31:0] SPITCH_MASK = 32'h0000_07FF;
	localparam logic [31:0] WIDTH_MASK = 32'h0000_FFFF;
	localparam logic [31:0] CFG_MASK = 32'h0000_0083;
	// Source type code for host data
	localparam logic [1:0] SRC_HOST = 2'h2;
	// Host-to-screen X masks
	localparam logic [15:0] HOST_X_COLOR = 16'h0007;
	localparam logic [15:0] HOST_X_BITMAP = 16'h001F;
	// Reset value of every operand register
	localparam logic [31:0] REG_RST = 32'h0000_0000;
	// Engine sequencer, Gray coded
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_RUN = 2'h1,
		ST_RUN_PEND = 2'h3
	} blt_state_t;
endpackage : blt_pkg

// ==== src/blt_regs.sv ====
// Our own choice: the APB register port.
`timescale 1ns/1ps
// Summary of operation
// - Packed bit keeps source as continuous stream
// - Packed clear discards leftover source per line
// - Expand bit selects bitmap source data
// - Pattern transparency skips zero pattern bytes
// - Bitmap transparency writes foreground on ones
// - Low byte holds raster operation code
// - Operands change only by software writes
// - Source base bits 4-0 read zero
// - Source address is base, X, Y products
// - Shift codes map to fixed Y multipliers
// - Pitch positive; direction from Y bit
// - Source X is bit address when expanding
// - Double-buffered registers; stall when pending full
// - Host transfers ignore Y and upper X
// - Status bit 31 shows engine busy
// - Status bit 30 shows pending, implies busy
// - Reads never stall; status always valid
// - Status flags read zero after reset
// - Width is byte count minus one
// - Command aperture loads width from address
// - Scratch register is plain read/write storage
// - Source key compare with match select
// - Destination key compare with match select
// - Destination coordinate write starts operation
module blt_regs (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic engine_busy_flag,
	output logic pending_flag,
	output logic [31:0] op_control,
	output logic [31:0] source_address,
	output logic [2:0] source_bit_offset,
	output logic source_y_reverse,
	output logic [15:0] byte_count,
	output logic [31:0] destination_start_coordinate,
	output logic [31:0] source_key_compare,
	output logic [31:0] destination_key_compare
);

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode

	logic pready_q; // Access-phase acknowledge
	logic [31:0] prdata_q; // Captured read data
	logic pslverr_q; // Unmapped-address answer
	logic [31:0] rop_q; // Raster operation control
	logic [31:0] cfg_q; // Depth and direction
	logic [31:0] sbase_q; // Source base
	logic [31:0] spitch_q; // Source shift fields
	logic [31:0] sxy_q; // Staged source coordinate
	logic [31:0] width_q; // Staged width
	logic [31:0] dxy_q; // Staged destination coordinate
	logic [31:0] scratch_q; // Free software storage
	logic [31:0] skey_q; // Source compare value
	logic [31:0] dkey_q; // Destination compare value
	blt_pkg::blt_state_t state_q; // Sequencer state
	blt_pkg::blt_state_t state_d;
	logic busy_q; // Status busy
	logic pend_q; // Status pending
	logic [13:0] cnt_q; // Dwords left in the operation
	logic [31:0] opctl_q; // Active control snapshot
	logic [31:0] saddr_q; // Active source address
	logic [2:0] sbit_q; // Bit offset in first byte
	logic ydir_q; // Active vertical direction
	logic [15:0] bcnt_q; // Active width
	logic [31:0] dxy_act_q; // Active destination coordinate
	logic [31:0] skey_act_q; // Active source key
	logic [31:0] dkey_act_q; // Active destination key
	logic [31:0] rd_data; // Read mux
	logic mapped; // Address decodes

	wire acc = psel & penable;
	wire hit_cmd = paddr[11:10] == blt_pkg::CMD_SEL;
	wire is_dst = (paddr == blt_pkg::OFF_DXY) | hit_cmd;
	// Writes that land in the staging copies
	wire dbuf_wr = pwrite & (is_dst | (paddr == blt_pkg::OFF_SXY)
		| (paddr == blt_pkg::OFF_WIDTH));
	// Staging is owned by the queued operation while pending is set
	wire stall = dbuf_wr & pend_q;
	wire fire = acc & pready_q;
	wire wr = fire & pwrite;
	wire start = wr & is_dst;
	wire done = busy_q & (cnt_q == 14'h0000);
	wire [15:0] cmd_count = {8'h00, paddr[9:2]};

	// Read mux; reads never look at the stall term
	always_comb begin
		rd_data = 32'h0000_0000;
		mapped = 1'b1;
		case (paddr)
			blt_pkg::OFF_CFG: rd_data = cfg_q;
			blt_pkg::OFF_ROP: rd_data = rop_q;
			blt_pkg::OFF_SBASE: rd_data = sbase_q;
			blt_pkg::OFF_SPITCH: rd_data = spitch_q;
			blt_pkg::OFF_SXY: rd_data = sxy_q;
			blt_pkg::OFF_WIDTH: rd_data = width_q;
			blt_pkg::OFF_DXY: rd_data = dxy_q;
			blt_pkg::OFF_SCR: rd_data = scratch_q;
			blt_pkg::OFF_SKEY: rd_data = skey_q;
			blt_pkg::OFF_DKEY: rd_data = dkey_q;
			blt_pkg::OFF_STAT: begin
				// Reserved status bits read zero
				rd_data[blt_pkg::STAT_BUSY] = busy_q;
				rd_data[blt_pkg::STAT_PEND] = pend_q;
			end
			default: begin
				// Command aperture is write-only and reads zero
				mapped = hit_cmd;
			end
		endcase
	end

	// Acknowledge one cycle into the access phase unless stalled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= acc & !pready_q & !stall;
			if (acc & !pready_q & !stall) begin
				prdata_q <= pwrite ? 32'h0000_0000 : rd_data;
				pslverr_q <= !mapped;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Software registers; no engine path writes them

	// Plain operand registers; a defined zero stands for undefined
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rop_q <= blt_pkg::REG_RST;
			cfg_q <= blt_pkg::REG_RST;
			sbase_q <= blt_pkg::REG_RST;
			spitch_q <= blt_pkg::REG_RST;
			scratch_q <= blt_pkg::REG_RST;
			skey_q <= blt_pkg::REG_RST;
			dkey_q <= blt_pkg::REG_RST;
		end else if (wr) begin
			case (paddr)
				blt_pkg::OFF_ROP: rop_q <= pwdata;
				blt_pkg::OFF_CFG: cfg_q <= pwdata & blt_pkg::CFG_MASK;
				blt_pkg::OFF_SBASE: sbase_q <= pwdata & blt_pkg::SBASE_MASK;
				blt_pkg::OFF_SPITCH: spitch_q <= pwdata & blt_pkg::SPITCH_MASK;
				blt_pkg::OFF_SCR: scratch_q <= pwdata;
				blt_pkg::OFF_SKEY: skey_q <= pwdata;
				blt_pkg::OFF_DKEY: dkey_q <= pwdata;
				default: begin
					// Other offsets handled by the staging process
				end
			endcase
		end
	end

	// Staging copies for the next operation
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sxy_q <= blt_pkg::REG_RST;
			width_q <= blt_pkg::REG_RST;
			dxy_q <= blt_pkg::REG_RST;
		end else if (wr) begin
			if (paddr == blt_pkg::OFF_SXY)
				sxy_q <= pwdata;
			if (paddr == blt_pkg::OFF_WIDTH)
				width_q <= pwdata & blt_pkg::WIDTH_MASK;
			if (hit_cmd)
				width_q <= {16'h0000, cmd_count};
			if (is_dst)
				dxy_q <= pwdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Source address generation

	// Y product of one shift field; unlisted codes give zero
	function automatic logic [31:0] yprod(input logic [1:0] f, input logic [2:0] c,
		input logic [15:0] y);
		logic [2:0] lo;
		logic [2:0] hi;
		logic [4:0] sh;
		lo = 3'h1;
		hi = 3'h5;
		sh = {2'h0, c} + 5'h04;
		case (f)
			2'h0: begin
				lo = 3'h3;
				hi = 3'h7;
			end
			2'h1: begin
				lo = 3'h2;
				hi = 3'h6;
			end
			2'h2: begin
				lo = 3'h1;
				hi = 3'h5;
			end
			default: begin
				// Top field starts at 1024
				lo = 3'h1;
				hi = 3'h3;
				sh = {2'h0, c} + 5'h09;
			end
		endcase
		yprod = (c >= lo && c <= hi) ? ({16'h0000, y} << sh) : 32'h0000_0000;
	endfunction : yprod

	wire host_src = rop_q[31:blt_pkg::ROP_SRC_LO] == blt_pkg::SRC_HOST;
	wire expand = rop_q[blt_pkg::ROP_EXPAND];
	// Host data ignores Y and all but the low X bits
	wire [15:0] x_eff = !host_src ? sxy_q[15:0]
		: sxy_q[15:0] & (expand ? blt_pkg::HOST_X_BITMAP : blt_pkg::HOST_X_COLOR);
	wire [15:0] y_eff = host_src ? 16'h0000 : sxy_q[31:16];
	// Bitmap X counts bits, so only the upper part moves the byte address
	wire [15:0] x_byte = expand ? {3'h0, x_eff[15:3]} : x_eff;

	logic [31:0] prod [4]; // Per-field Y products
	for (genvar g = 0; g < 4; g++) begin : g_prod
		// Top field is only two bits wide
		wire [2:0] code = (g == 3) ? {1'b0, spitch_q[10:9]} : spitch_q[3*g+2 -: 3];
		assign prod[g] = yprod(2'(g), code, y_eff);
	end
	wire [31:0] src_addr = sbase_q + {16'h0000, x_byte} + prod[0] + prod[1]
		+ prod[2] + prod[3];

	////////////////////////////////////////////////////////////////////////////////
	// Operation sequencer

	// A start while running with pending free is queued; a start when idle or at done runs at once
	always_comb begin
		state_d = state_q;
		case (state_q)
			blt_pkg::ST_IDLE:
				if (start)
					state_d = blt_pkg::ST_RUN;
			blt_pkg::ST_RUN:
				if (done)
					state_d = start ? blt_pkg::ST_RUN : blt_pkg::ST_IDLE;
				else if (start)
					state_d = blt_pkg::ST_RUN_PEND;
			blt_pkg::ST_RUN_PEND:
				if (done)
					state_d = blt_pkg::ST_RUN;
			default: state_d = blt_pkg::ST_IDLE;
		endcase
	end

	wire launch = (state_q == blt_pkg::ST_IDLE & start)
		| (done & (start | state_q == blt_pkg::ST_RUN_PEND));
	// Command writes carry their own width
	wire [15:0] nxt_width = (wr & hit_cmd) ? cmd_count : width_q[15:0];
	wire [31:0] nxt_dxy = start ? pwdata : dxy_q;

	// State and status flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= blt_pkg::ST_IDLE;
			busy_q <= 1'b0;
			pend_q <= 1'b0;
		end else begin
			state_q <= state_d;
			busy_q <= state_d != blt_pkg::ST_IDLE;
			pend_q <= state_d == blt_pkg::ST_RUN_PEND;
		end
	end

	// Active copies are taken at launch, so software may restage unless pending is set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 14'h0000;
			opctl_q <= blt_pkg::REG_RST;
			saddr_q <= blt_pkg::REG_RST;
			sbit_q <= 3'h0;
			ydir_q <= 1'b0;
			bcnt_q <= 16'h0000;
			dxy_act_q <= blt_pkg::REG_RST;
			skey_act_q <= blt_pkg::REG_RST;
			dkey_act_q <= blt_pkg::REG_RST;
		end else if (launch) begin
			// One dword per cycle over width plus one bytes
			cnt_q <= nxt_width[15:2];
			// Packed, expand, key and match bits go to the pixel path
			opctl_q <= rop_q;
			saddr_q <= src_addr;
			sbit_q <= expand ? x_eff[2:0] : 3'h0;
			ydir_q <= cfg_q[blt_pkg::CFG_YDIR];
			bcnt_q <= nxt_width;
			dxy_act_q <= nxt_dxy;
			skey_act_q <= skey_q;
			dkey_act_q <= dkey_q;
		end else if (busy_q & !done) begin
			cnt_q <= cnt_q - 14'h0001;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign engine_busy_flag = busy_q;
	assign pending_flag = pend_q;
	assign op_control = opctl_q;
	assign source_address = saddr_q;
	assign source_bit_offset = sbit_q;
	assign source_y_reverse = ydir_q;
	assign byte_count = bcnt_q;
	assign destination_start_coordinate = dxy_act_q;
	assign source_key_compare = skey_act_q;
	assign destination_key_compare = dkey_act_q;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_idle_start;
		state_q == blt_pkg::ST_IDLE && start;
	endsequence
	sequence s_read_req;
		acc && !pwrite && !pready_q;
	endsequence

	property p_pend_busy;
		pend_q |-> busy_q;
	endproperty
	a_pend_busy: assert property (p_pend_busy) else $error("pending without busy");

	property p_stall;
		acc && dbuf_wr && pend_q |=> !pready_q;
	endproperty
	a_stall: assert property (p_stall) else $error("staged write not held off");

	property p_read_fast;
		s_read_req |=> pready_q;
	endproperty
	a_read_fast: assert property (p_read_fast) else $error("read stalled");

	property p_start_busy;
		s_idle_start |=> busy_q && !pend_q;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("start did not set busy");

	property p_end_idle;
		state_q == blt_pkg::ST_RUN && done && !start |=> !busy_q;
	endproperty
	a_end_idle: assert property (p_end_idle) else $error("busy after end");

	property p_sbase_low;
		sbase_q[4:0] == 5'h00;
	endproperty
	a_sbase_low: assert property (p_sbase_low) else $error("base low bits set");

	property p_scratch;
		wr && paddr == blt_pkg::OFF_SCR |=> scratch_q == $past(pwdata);
	endproperty
	a_scratch: assert property (p_scratch) else $error("scratch not stored");

	property p_cmd_width;
		s_idle_start ##0 hit_cmd |=> bcnt_q == {8'h00, $past(paddr[9:2])};
	endproperty
	a_cmd_width: assert property (p_cmd_width) else $error("count not loaded");

	property p_rop_hold;
		busy_q && !launch |=> $stable(opctl_q);
	endproperty
	a_rop_hold: assert property (p_rop_hold) else $error("active control changed");

	property p_stat_read;
		s_read_req ##0 paddr == blt_pkg::OFF_STAT
			|=> prdata_q[blt_pkg::STAT_BUSY] == $past(busy_q);
	endproperty
	a_stat_read: assert property (p_stat_read) else $error("status read wrong");

endmodule : blt_regs

// ==== testbench/blt_host_model.sv ====
`timescale 1ns/1ps
////////////////////////////////////////
// Host CPU: one APB transfer per go
module blt_host_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire logic we,
	input wire logic [11:0] ad,
	input wire logic [31:0] wd,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	output logic done,
	output logic [31:0] rdata,
	output logic err
);
	// Setup, access held until pready, then release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{psel, penable, pwrite, done, err} <= '0;
			paddr <= 12'h000;
			pwdata <= 32'h0000_0000;
			rdata <= 32'h0000_0000;
		end else begin
			done <= 1'b0;
			if (psel && penable && pready) begin // Stalled host waits here
				psel <= 1'b0;
				penable <= 1'b0;
				// Released data must not look still valid
				pwdata <= ~pwdata;
				done <= 1'b1;
				rdata <= prdata;
				err <= pslverr;
			end else if (psel) begin
				penable <= 1'b1;
			end else if (go) begin
				psel <= 1'b1;
				pwrite <= we;
				paddr <= ad;
				pwdata <= wd;
			end
		end
	end
endmodule : blt_host_model

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb;
	logic pclk = 1'b0;
	logic presetn = 1'b1; // Dropped at time zero by NBA
	logic go = 1'b0;
	logic we = 1'b0;
	logic [11:0] ad = 12'h000;
	logic [31:0] wd = 32'h0000_0000;
	logic psel, penable, pwrite, pready, pslverr, done, err, busy, pend, yrev;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata, opc, saddr, dxy, skey, dkey;
	logic [2:0] boff;
	logic [15:0] bcnt;
	int fail_count = 0;
	int n_checks = 0;
	int cyc = 0; // Hang guard
	always #10 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			end_of_test();
		end
	end
	////////////////////////////////////////
	blt_host_model host_u (.pclk(pclk), .presetn(presetn), .go(go), .we(we), .ad(ad),
		.wd(wd), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .done(done),
		.rdata(rdata), .err(err));
	blt_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .engine_busy_flag(busy), .pending_flag(pend), .op_control(opc),
		.source_address(saddr), .source_bit_offset(boff), .source_y_reverse(yrev),
		.byte_count(bcnt), .destination_start_coordinate(dxy), .source_key_compare(skey),
		.destination_key_compare(dkey));
	////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// One bus transfer; waits for the host model, bounded
	task automatic io(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		go <= 1'b1;
		we <= w;
		ad <= a;
		wd <= d;
		@(posedge pclk);
		go <= 1'b0;
		do begin
			@(posedge pclk);
			#1;
			k++;
		end while (done !== 1'b1 && k < 600);
		if (k >= 600) chk("bus wait", 32'h1, 32'h0);
	endtask : io
	task automatic rd(input string n, input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] e);
		io(1'b0, a, 32'h0000_0000);
		chk(n, e, rdata & m);
	endtask : rd
	// Engine drains; bounded so a stuck busy shows
	task automatic idle();
		int k;
		k = 0;
		while (busy !== 1'b0 && k < 2000) begin
			@(posedge pclk);
			#1;
			k++;
		end
		chk("busy idle", 32'h0, {31'h0, busy});
	endtask : idle
	task automatic launch(input logic [31:0] raster_op_control, input logic [31:0] pit,
		input logic [31:0] sxy, input logic [31:0] ea, input logic [2:0] eo);
		io(1'b1, blt_pkg::OFF_ROP, raster_op_control);
		io(1'b1, blt_pkg::OFF_SBASE, 32'h0000_1000);
		io(1'b1, blt_pkg::OFF_SPITCH, pit);
		io(1'b1, blt_pkg::OFF_SXY, sxy);
		io(1'b1, blt_pkg::OFF_WIDTH, 32'h0000_0007); // Multiple of depth
		io(1'b1, blt_pkg::OFF_DXY, 32'h0010_0020); // Final write starts it
		@(posedge pclk);
		#1;
		chk("op_control", raster_op_control, opc);
		chk("source_address", ea, saddr);
		chk("bit_offset", {29'h0, eo}, {29'h0, boff});
		chk("byte_count", 32'h0000_0007, {16'h0, bcnt});
		chk("dest_coord", 32'h0010_0020, dxy);
		chk("src_key", 32'h1212_1212, skey);
		chk("dst_key", 32'h3456_3456, dkey);
		idle();
	endtask : launch
	////////////////////////////////////////
	task automatic t_reset();
		rd("status", blt_pkg::OFF_STAT, 32'hC000_0000, 32'h0);
		chk("pending", 32'h0, {31'h0, pend});
		$display("test reset done");
	endtask : t_reset
	task automatic t_regs();
		logic [11:0] ta[6];
		logic [31:0] tw[6];
		logic [31:0] te[6];
		ta = '{blt_pkg::OFF_SCR, blt_pkg::OFF_SBASE, blt_pkg::OFF_SPITCH,
			blt_pkg::OFF_WIDTH, blt_pkg::OFF_SKEY, blt_pkg::OFF_DKEY};
		tw = '{32'hA5A5_5A5A, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
			32'h1212_1212, 32'h3456_3456}; // Replicated keys
		te = '{32'hA5A5_5A5A, 32'h003F_FFE0, 32'h0000_07FF, 32'h0000_FFFF,
			32'h1212_1212, 32'h3456_3456};
		for (int i = 0; i < 6; i++) begin
			io(1'b1, ta[i], tw[i]);
			rd("reg readback", ta[i], 32'hFFFF_FFFF, te[i]);
		end
		chk("mapped err", 32'h0, {31'h0, err});
		rd("unmapped", 12'h010, 32'hFFFF_FFFF, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, err});
		io(1'b1, blt_pkg::OFF_STAT, 32'hFFFF_FFFF);
		rd("status ro", blt_pkg::OFF_STAT, 32'hC000_0000, 32'h0);
		$display("test regs done");
	endtask : t_regs
	task automatic t_addr();
		logic [31:0] rops[5];
		rops = '{32'h4000_00CC, 32'h4000_08CC, 32'h4000_F0CC, 32'h2000_02F0, 32'h4000_0033};
		for (int i = 0; i < 5; i++) begin
			launch(rops[i], 32'h0000_0003, 32'h0002_0005, 32'h0000_1105, 3'h0);
		end
		launch(32'h4000_00CC, 32'h0000_0717, 32'h0002_0005, 32'h0000_4285, 3'h0);
		launch(32'h4000_00CC, 32'h0000_003F, 32'h0002_0005, 32'h0000_2005, 3'h0);
		io(1'b1, blt_pkg::OFF_CFG, 32'h0000_0080);
		launch(32'h4000_00CC, 32'h0000_0180, 32'h0002_0005, 32'h0000_1005, 3'h0);
		chk("y_reverse", 32'h1, {31'h0, yrev});
		io(1'b1, blt_pkg::OFF_CFG, 32'h0000_0000);
		launch(32'h4000_05CC, 32'h0000_0003, 32'h0002_0013, 32'h0000_1102, 3'h3);
		launch(32'h8000_00CC, 32'h0000_0003, 32'h0002_00FD, 32'h0000_1005, 3'h0);
		launch(32'h8000_04CC, 32'h0000_0003, 32'h0002_00FD, 32'h0000_1003, 3'h5);
		$display("test addr done");
	endtask : t_addr
	task automatic t_pend();
		io(1'b1, blt_pkg::OFF_WIDTH, 32'h0000_03FF);
		io(1'b1, blt_pkg::OFF_DXY, 32'h0000_0000);
		io(1'b1, blt_pkg::OFF_SXY, 32'h0000_0009); // Staged while busy
		io(1'b1, blt_pkg::OFF_DXY, 32'h0000_0001);
		rd("status", blt_pkg::OFF_STAT, 32'hC000_0000, 32'hC000_0000);
		io(1'b1, blt_pkg::OFF_WIDTH, 32'h0000_0007);
		chk("pending", 32'h0, {31'h0, pend}); // Write held off till queue moved
		chk("busy", 32'h1, {31'h0, busy});
		chk("queued width", 32'h0000_03FF, {16'h0, bcnt});
		chk("queued dest", 32'h0000_0001, dxy);
		rd("base kept", blt_pkg::OFF_SBASE, 32'hFFFF_FFFF, 32'h0000_1000);
		idle();
		rd("status", blt_pkg::OFF_STAT, 32'hC000_0000, 32'h0);
		$display("test pend done");
	endtask : t_pend
	task automatic t_cmd();
		io(1'b1, 12'h440, 32'h0003_0004); // Count 0x10 in address
		@(posedge pclk);
		#1;
		chk("cmd count", 32'h0000_0010, {16'h0, bcnt});
		chk("cmd dest", 32'h0003_0004, dxy);
		idle();
		rd("width", blt_pkg::OFF_WIDTH, 32'hFFFF_FFFF, 32'h0000_0010);
		$display("test cmd done");
	endtask : t_cmd
	////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test
	initial begin
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_regs();
		t_addr();
		t_pend();
		t_cmd();
		end_of_test();
	end
endmodule : tb
